/* pkg/rtseq_pkg.sv */
package rtseq_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned POWERUP_DELAY_PERIOD_MS = 72;
   localparam int unsigned POWERUP_DELAY_CYCLES =
      (POWERUP_DELAY_PERIOD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BROWNOUT_MIN_DURATION_US = 100;
   localparam int unsigned BROWNOUT_MIN_CYCLES =
      (BROWNOUT_MIN_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PIN_FILTER_NS = 200;
   localparam int unsigned PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OSC_STARTUP_COUNT = 1024;

   localparam int unsigned POWERUP_DELAY_TIMER_CNT_W = 21;
   localparam int unsigned BOR_CNT_W = 11;
   localparam int unsigned OST_CNT_W = 11;
   localparam int unsigned FILT_CNT_W = 3;

   // ****************************************************************
   // oscillator modes and reset causes
   // ****************************************************************
   localparam logic [1:0] RESISTOR_CAP_OSC_MODE = 2'h3;
   localparam logic [1:0] HIGH_SPEED_CRYSTAL_MODE = 2'h2;
   localparam logic [1:0] STANDARD_CRYSTAL_MODE = 2'h1;
   localparam logic [1:0] LOW_POWER_CRYSTAL_MODE = 2'h0;

   localparam logic [2:0] CAUSE_POWER_ON = 3'h0;
   localparam logic [2:0] CAUSE_PIN_RUN = 3'h1;
   localparam logic [2:0] CAUSE_PIN_SLEEP = 3'h2;
   localparam logic [2:0] CAUSE_WDT_RESET = 3'h3;
   localparam logic [2:0] CAUSE_WDT_WAKE = 3'h4;
   localparam logic [2:0] CAUSE_BROWNOUT = 3'h5;
   localparam logic [2:0] CAUSE_IRQ_WAKE = 3'h6;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] STATUS_OFFSET = 12'h000;
   localparam logic [11:0] POWER_CONTROL_REGISTER_OFFSET = 12'h004;
   localparam logic [11:0] FLAG_CONTROL_OFFSET = 12'h008;
   localparam logic [11:0] RETAIN_OFFSET = 12'h00C;

   localparam int unsigned ST_TIMEOUT_BIT = 0;
   localparam int unsigned ST_POWERDOWN_BIT = 1;
   localparam int unsigned ST_CAUSE_LSB = 4;
   localparam int unsigned ST_STATE_LSB = 8;
   localparam int unsigned ST_CORE_RESET_BIT = 16;
   localparam int unsigned ST_CORE_STALL_BIT = 17;
   localparam int unsigned PCR_BROWNOUT_BIT = 0;
   localparam int unsigned PCR_POWER_ON_BIT = 1;
   localparam int unsigned FC_RESTORE_BIT = 0;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [1:0] osc_mode_fuses;
      logic powerup_delay_enable_fuse;
      logic brownout_enable_fuse;
   } rtseq_fuse_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } rtseq_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rtseq_apb_rsp_t;

   typedef struct packed {
      logic [2:0] cause;
      logic timeout_flag;
      logic powerdown_flag;
   } rtseq_status_t;

endpackage

/* hw/rtseq_top.sv */
`timescale 1ns/1ps

// Summary of operation
// - each reset is classed as power-on, pin run, pin sleep, watchdog, wake or brown-out
// - the retained register is never touched by any reset
// - core registers initialise on every reset cause except watchdog or interrupt wake-up
// - a filter drops short pulses on the external reset pin
// - watchdog reset acts inside only; the external pin is never driven
// - power-up delay of 72 ms holds reset, only after power-on or brown-out
// - power-up delay counts core clock cycles and has a configuration enable
// - start-up counter counts 1024 oscillator input rising edges after the power-up delay
// - start-up count only in crystal modes, on power-on or wake-up
// - enabled brown-out resets after low supply lasting 100 us
// - brown-out holds reset while supply is low, then full power-up delay
// - supply dipping during the power-up delay restarts the brown-out sequence
// - enabled brown-out forces the power-up delay on
// - power-up runs delay, then start-up count, then leaves reset
// - pin held low through all delays starts execution on its release
// - timeout and powerdown flags record the reset cause
// - high-speed mode accepts an external clock on the oscillator input
// - oscillator mode codes: 11 rc, 10 high-speed, 01 standard, 00 low-power
// - power-up delay enable fuse is active low
// - flags: 11 power/brown-out, 01 watchdog, 00 watchdog wake, 10 pin sleep or interrupt wake
// - power-on status bit cleared by power-on, else kept until software sets
module rtseq_top
   import rtseq_pkg::*;
#(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pins and supply detectors
   input wire logic external_reset_pin_n,
   input wire logic osc_input_pin,
   input wire logic por_detect,
   input wire logic low_supply,
   // configuration fuses
   input wire rtseq_fuse_t fuses,
   // core events
   input wire logic sleep_enter,
   input wire logic watchdog_timeout,
   input wire logic irq_wake,
   // register bus
   input wire rtseq_apb_req_t apb_req,
   output rtseq_apb_rsp_t apb_rsp,
   // core control and status
   output logic core_reset,
   output logic core_stall,
   output logic core_wake,
   output rtseq_status_t status
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic is_crystal(input logic [1:0] mode);
      // high-speed covers an external clock on the same input
      is_crystal = (mode != RESISTOR_CAP_OSC_MODE);
   endfunction

   function automatic logic is_wake(input logic [2:0] c);
      is_wake = (c == CAUSE_WDT_WAKE) || (c == CAUSE_IRQ_WAKE);
   endfunction

   function automatic logic is_power_cause(input logic [2:0] c);
      is_power_cause = (c == CAUSE_POWER_ON) || (c == CAUSE_BROWNOUT);
   endfunction

   typedef enum logic [4:0] {
      ST_HOLD = 5'h01,
      ST_POWERUP_DELAY_TIMER = 5'h02,
      ST_OST = 5'h04,
      ST_RUN = 5'h08,
      ST_SLEEP = 5'h10
   } rtseq_state_t;

   rtseq_state_t state;
   rtseq_state_t next_state;
   logic [2:0] cause;
   logic [2:0] next_cause;
   logic cause_load;
   logic wake_seq;
   logic next_wake_seq;
   logic [1:0] pin_sync;
   logic [1:0] osc_sync;
   logic [1:0] por_sync;
   logic [1:0] low_sync;
   logic osc_prev;
   logic osc_rise;
   logic pin_low;
   logic pin_low_prev;
   logic [FILT_CNT_W-1:0] filt_cnt;
   logic [BOR_CNT_W-1:0] bor_cnt;
   logic bor_en;
   logic bor_low;
   logic bor_trip;
   logic [POWERUP_DELAY_TIMER_CNT_W-1:0] powerup_delay_timer_cnt;
   logic [OST_CNT_W-1:0] ost_cnt;
   logic powerup_delay_timer_done;
   logic ost_done;
   logic uses_powerup_delay_timer;
   logic ost_needed;
   logic por_status;
   logic bor_status;
   logic [31:0] retain;
   logic bus_setup;
   logic bus_access;
   logic addr_hit;
   logic wr_pcr;
   logic wr_flag;
   logic wr_retain;
   logic [31:0] rd_data;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_sync <= 2'h3;
         osc_sync <= 2'h0;
         por_sync <= 2'h0;
         low_sync <= 2'h0;
      end else begin
         pin_sync <= {pin_sync[0], external_reset_pin_n};
         osc_sync <= {osc_sync[0], osc_input_pin};
         por_sync <= {por_sync[0], por_detect};
         low_sync <= {low_sync[0], low_supply};
      end
   end

   // oscillator edges counted in the core clock once synchronised
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= osc_sync[1];
      end
   end
   assign osc_rise = osc_sync[1] & ~osc_prev;

   // ****************************************************************
   // external reset pin filter
   // ****************************************************************
   // a level change must persist for the filter time before it counts
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         filt_cnt <= '0;
         pin_low <= 1'b0;
         pin_low_prev <= 1'b0;
      end else begin
         pin_low_prev <= pin_low;
         if (pin_sync[1] != pin_low) begin
            filt_cnt <= '0;
         end else if (filt_cnt == FILT_CNT_W'(PIN_FILTER_CYCLES - 1)) begin
            filt_cnt <= '0;
            pin_low <= ~pin_low;
         end else begin
            filt_cnt <= filt_cnt + FILT_CNT_W'(1);
         end
      end
   end

   // ****************************************************************
   // brown-out detection
   // ****************************************************************
   assign bor_en = fuses.brownout_enable_fuse;
   assign bor_low = bor_en & low_sync[1];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bor_cnt <= '0;
      end else if (!bor_low) begin
         bor_cnt <= '0;
      end else if (bor_cnt != BOR_CNT_W'(BROWNOUT_MIN_CYCLES)) begin
         bor_cnt <= bor_cnt + BOR_CNT_W'(1);
      end
   end

   // trips once, when the dip reaches the minimum duration
   assign bor_trip = bor_low && (bor_cnt == BOR_CNT_W'(BROWNOUT_MIN_CYCLES - 1));

   // ****************************************************************
   // sequencer
   // ****************************************************************
   assign uses_powerup_delay_timer = is_power_cause(cause) &&
      (!fuses.powerup_delay_enable_fuse || bor_en);
   assign ost_needed = is_crystal(fuses.osc_mode_fuses) &&
      (cause == CAUSE_POWER_ON || is_wake(cause));
   assign powerup_delay_timer_done = (powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1));
   assign ost_done = osc_rise && (ost_cnt == OST_CNT_W'(OSC_STARTUP_COUNT - 1));

   always_comb begin
      next_state = state;
      next_cause = cause;
      cause_load = 1'b0;
      if (por_sync[1]) begin
         next_state = ST_HOLD;
         next_cause = CAUSE_POWER_ON;
         cause_load = 1'b1;
      end else if (bor_trip) begin
         next_state = ST_HOLD;
         next_cause = CAUSE_BROWNOUT;
         cause_load = 1'b1;
      end else begin
         case (state)
            ST_HOLD: begin
               // pin level does not block the delays
               if (!bor_low) begin
                  if (uses_powerup_delay_timer) begin
                     next_state = ST_POWERUP_DELAY_TIMER;
                  end else if (ost_needed) begin
                     next_state = ST_OST;
                  end else begin
                     next_state = ST_RUN;
                  end
               end
            end
            ST_POWERUP_DELAY_TIMER: begin
               if (bor_low) begin
                  next_state = ST_HOLD;
               end else if (powerup_delay_timer_done) begin
                  next_state = ost_needed ? ST_OST : ST_RUN;
               end
            end
            ST_OST: begin
               if (ost_done) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (pin_low && !pin_low_prev) begin
                  next_cause = CAUSE_PIN_RUN;
                  cause_load = 1'b1;
               end else if (watchdog_timeout) begin
                  // internal reset only, one cycle through the hold state
                  next_state = ST_HOLD;
                  next_cause = CAUSE_WDT_RESET;
                  cause_load = 1'b1;
               end else if (sleep_enter) begin
                  next_state = ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (pin_low && !pin_low_prev) begin
                  next_state = ST_RUN;
                  next_cause = CAUSE_PIN_SLEEP;
                  cause_load = 1'b1;
               end else if (watchdog_timeout || irq_wake) begin
                  next_state = is_crystal(fuses.osc_mode_fuses) ? ST_OST : ST_RUN;
                  next_cause = watchdog_timeout ? CAUSE_WDT_WAKE : CAUSE_IRQ_WAKE;
                  cause_load = 1'b1;
               end
            end
            default: begin
               next_state = ST_HOLD;
            end
         endcase
      end
   end

   assign next_wake_seq = cause_load ? is_wake(next_cause) : wake_seq;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= ST_HOLD;
         cause <= CAUSE_POWER_ON;
         wake_seq <= 1'b0;
      end else begin
         state <= next_state;
         cause <= next_cause;
         wake_seq <= next_wake_seq;
      end
   end

   // ****************************************************************
   // stage counters
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         powerup_delay_timer_cnt <= '0;
      end else if (state != ST_POWERUP_DELAY_TIMER || cause_load) begin
         powerup_delay_timer_cnt <= '0;
      end else if (!powerup_delay_timer_done) begin
         powerup_delay_timer_cnt <= powerup_delay_timer_cnt + POWERUP_DELAY_TIMER_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ost_cnt <= '0;
      end else if (state != ST_OST || cause_load) begin
         ost_cnt <= '0;
      end else if (osc_rise) begin
         ost_cnt <= ost_cnt + OST_CNT_W'(1);
      end
   end

   // ****************************************************************
   // core control outputs
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         core_reset <= 1'b1;
         core_stall <= 1'b1;
         core_wake <= 1'b0;
      end else begin
         // wake-up stalls the core but leaves its registers alone
         core_reset <= ((next_state != ST_RUN) && (next_state != ST_SLEEP) && !next_wake_seq)
            || pin_low;
         core_stall <= (next_state != ST_RUN) || pin_low;
         core_wake <= (next_state == ST_RUN) && (state != ST_RUN) && next_wake_seq;
      end
   end

   // ****************************************************************
   // reset flags
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         status.cause <= CAUSE_POWER_ON;
         status.timeout_flag <= 1'b1;
         status.powerdown_flag <= 1'b1;
      end else begin
         status.cause <= next_cause;
         if (cause_load) begin
            case (next_cause)
               CAUSE_WDT_RESET: begin
                  status.timeout_flag <= 1'b0;
                  status.powerdown_flag <= 1'b1;
               end
               CAUSE_WDT_WAKE: begin
                  status.timeout_flag <= 1'b0;
                  status.powerdown_flag <= 1'b0;
               end
               CAUSE_PIN_SLEEP, CAUSE_IRQ_WAKE: begin
                  status.timeout_flag <= 1'b1;
                  status.powerdown_flag <= 1'b0;
               end
               CAUSE_PIN_RUN: begin
                  status.timeout_flag <= status.timeout_flag;
                  status.powerdown_flag <= status.powerdown_flag;
               end
               default: begin
                  status.timeout_flag <= 1'b1;
                  status.powerdown_flag <= 1'b1;
               end
            endcase
         end else if (state == ST_RUN && sleep_enter) begin
            status.timeout_flag <= 1'b1;
            status.powerdown_flag <= 1'b0;
         end else if (wr_flag && apb_req.pwdata[FC_RESTORE_BIT]) begin
            status.timeout_flag <= 1'b1;
            status.powerdown_flag <= 1'b1;
         end
      end
   end

   // hardware clear beats a software set in the same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         por_status <= 1'b0;
         bor_status <= 1'b0;
      end else begin
         if (cause_load && next_cause == CAUSE_POWER_ON) begin
            por_status <= 1'b0;
         end else if (wr_pcr && apb_req.pwdata[PCR_POWER_ON_BIT]) begin
            por_status <= 1'b1;
         end
         if (cause_load && next_cause == CAUSE_BROWNOUT) begin
            bor_status <= 1'b0;
         end else if (wr_pcr && apb_req.pwdata[PCR_BROWNOUT_BIT]) begin
            bor_status <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // register bus
   // ****************************************************************
   assign bus_setup = apb_req.psel & ~apb_req.penable;
   assign bus_access = apb_req.psel & apb_req.penable;
   assign addr_hit = (apb_req.paddr == STATUS_OFFSET)
      || (apb_req.paddr == POWER_CONTROL_REGISTER_OFFSET)
      || (apb_req.paddr == FLAG_CONTROL_OFFSET)
      || (apb_req.paddr == RETAIN_OFFSET);
   assign wr_pcr = bus_access && apb_req.pwrite && (apb_req.paddr == POWER_CONTROL_REGISTER_OFFSET);
   assign wr_flag = bus_access && apb_req.pwrite && (apb_req.paddr == FLAG_CONTROL_OFFSET);
   assign wr_retain = bus_access && apb_req.pwrite && (apb_req.paddr == RETAIN_OFFSET);
   assign apb_rsp = '{rd_data, bus_access, bus_access & ~addr_hit};

   // kept across every reset, including the bus reset
   always_ff @(posedge clk_sys) begin
      if (wr_retain) begin
         retain <= apb_req.pwdata;
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_data <= '0;
      end else if (bus_setup) begin
         rd_data <= '0;
         case (apb_req.paddr)
            STATUS_OFFSET: begin
               rd_data[ST_TIMEOUT_BIT] <= status.timeout_flag;
               rd_data[ST_POWERDOWN_BIT] <= status.powerdown_flag;
               rd_data[ST_CAUSE_LSB +: 3] <= status.cause;
               rd_data[ST_STATE_LSB +: 5] <= state;
               rd_data[ST_CORE_RESET_BIT] <= core_reset;
               rd_data[ST_CORE_STALL_BIT] <= core_stall;
            end
            POWER_CONTROL_REGISTER_OFFSET: begin
               rd_data[PCR_POWER_ON_BIT] <= por_status;
               rd_data[PCR_BROWNOUT_BIT] <= bor_status;
            end
            RETAIN_OFFSET: begin
               rd_data <= retain;
            end
            default: begin
               rd_data <= '0;
            end
         endcase
      end
   end

endmodule // rtseq_top

/* verification/rtseq_partner.sv */
`timescale 1ns/1ps
// ****************************************************************
// far side: crystal and power-on detector
// ****************************************************************
module rtseq_partner (
   // oscillator control
   input wire logic osc_en,
   // pins toward the sequencer
   output logic osc_input_pin,
   output logic por_detect
);
   initial begin
      por_detect = 1'b1;
      #300 por_detect = 1'b0;
   end
   // crystal or external clock, still while disabled
   initial begin
      osc_input_pin = 1'b0;
      forever #75 osc_input_pin = osc_en ? ~osc_input_pin : 1'b0;
   end
endmodule // rtseq_partner

/* verification/rtseq_monitor.sv */
`timescale 1ns/1ps
// ****************************************************************
// checker
// ****************************************************************
module rtseq_checker
   import rtseq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // bus and core side
   input wire rtseq_apb_req_t apb_req,
   input wire rtseq_apb_rsp_t apb_rsp,
   input wire logic core_reset,
   input wire logic core_stall,
   input wire logic core_wake,
   input wire rtseq_status_t status
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   AST_HOLD_AFTER_RESET: assert property ($fell(reset) |-> core_reset && core_stall)
      else $error("core left reset too early");
   AST_STALL_IN_RESET: assert property (core_reset |-> core_stall)
      else $error("core runs while in reset");
   AST_WAKE_NOT_RESET: assert property (core_wake |-> !core_reset)
      else $error("wake forced core reset");
   AST_WAKE_PULSE: assert property (core_wake |=> !core_wake)
      else $error("wake pulse too long");
   AST_WDT_FLAGS: assert property ($changed(status.cause) && status.cause == CAUSE_WDT_RESET
      |-> !status.timeout_flag && status.powerdown_flag)
      else $error("watchdog flags wrong");
   AST_WAKE_FLAGS: assert property ($changed(status.cause) && status.cause == CAUSE_WDT_WAKE
      |-> !status.timeout_flag && !status.powerdown_flag)
      else $error("wake flags wrong");
   AST_BROWN_FLAGS: assert property ($changed(status.cause) && status.cause == CAUSE_BROWNOUT
      |-> status.timeout_flag && status.powerdown_flag)
      else $error("brown-out flags wrong");
   AST_SLEEP_PIN_FLAGS: assert property ($changed(status.cause) && status.cause == CAUSE_PIN_SLEEP
      |-> status.timeout_flag && !status.powerdown_flag)
      else $error("pin sleep flags wrong");
   AST_WDT_SHORT: assert property ($changed(status.cause) && status.cause == CAUSE_WDT_RESET
      |-> ##[1:4] !core_reset)
      else $error("watchdog reset ran delays");
   AST_NO_WAIT: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
      else $error("bus wait state");
   AST_UNMAPPED: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > 12'h00C
      |-> apb_rsp.pslverr)
      else $error("unmapped access not refused");
endmodule // rtseq_checker

bind rtseq_top rtseq_checker u_chk (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .core_reset(core_reset), .core_stall(core_stall),
   .core_wake(core_wake), .status(status));

/* verification/test_reset_timeout_sequencer.sv */
`timescale 1ns/1ps
module test_reset_timeout_sequencer;
   import rtseq_pkg::*;
   localparam int PW = 20;
   logic clk_sys, reset, pin_n, low_supply, sleep_enter, watchdog_timeout, irq_wake, osc_en;
   logic osc_input_pin, por_detect, core_reset, core_stall, core_wake, err;
   logic [31:0] rd;
   rtseq_fuse_t fuses;
   rtseq_apb_req_t req;
   rtseq_apb_rsp_t rsp;
   rtseq_status_t status;
   int bad_count = 0;
   int num_checks = 0;
   int n;

   rtseq_top #(.POWERUP_DELAY_TIMER_CYCLES(PW)) uut (.clk_sys(clk_sys), .reset(reset),
      .external_reset_pin_n(pin_n), .osc_input_pin(osc_input_pin), .por_detect(por_detect),
      .low_supply(low_supply), .fuses(fuses), .sleep_enter(sleep_enter),
      .watchdog_timeout(watchdog_timeout), .irq_wake(irq_wake), .apb_req(req),
      .apb_rsp(rsp), .core_reset(core_reset), .core_stall(core_stall),
      .core_wake(core_wake), .status(status));
   rtseq_partner u_far (.osc_en(osc_en), .osc_input_pin(osc_input_pin),
      .por_detect(por_detect));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (rsp.pready !== 1'b1 && i < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // one-cycle core event: 0 sleep, 1 watchdog, 2 interrupt
   task ev(input int k);
      @(posedge clk_sys);
      {irq_wake, watchdog_timeout, sleep_enter} <= 3'(1 << k);
      @(posedge clk_sys);
      {irq_wake, watchdog_timeout, sleep_enter} <= 3'h0;
      repeat (3) @(posedge clk_sys);
   endtask
   task run_time(output int c);
      c = 0;
      while (core_stall !== 1'b0 && c < 6000) begin
         @(posedge clk_sys);
         c++;
      end
   endtask
   task pin_low(input int k);
      @(posedge clk_sys);
      pin_n <= 1'b0;
      repeat (k) @(posedge clk_sys);
      pin_n <= 1'b1;
   endtask
   task supply_low(input int k);
      @(posedge clk_sys);
      low_supply <= 1'b1;
      repeat (k) @(posedge clk_sys);
      low_supply <= 1'b0;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      reset = 1'b1;
      pin_n = 1'b1;
      low_supply = 1'b0;
      {irq_wake, watchdog_timeout, sleep_enter} = 3'h0;
      osc_en = 1'b1;
      req = '0;
      fuses = '{HIGH_SPEED_CRYSTAL_MODE, 1'b0, 1'b0};
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      run_time(n);
      chk(32'(n > PW + 3000 && n < 5000), 32'h1);
      chk({core_reset, status}, {1'b0, CAUSE_POWER_ON, 2'h3});
      apb(1'b0, POWER_CONTROL_REGISTER_OFFSET, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, POWER_CONTROL_REGISTER_OFFSET, 32'h3);
      apb(1'b1, RETAIN_OFFSET, 32'hA5C3_3C5A);
      apb(1'b0, 12'h010, 32'h0);
      chk(err, 1'b1);
      ev(1);
      chk(status, {CAUSE_WDT_RESET, 2'h1});
      apb(1'b0, POWER_CONTROL_REGISTER_OFFSET, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, RETAIN_OFFSET, 32'h0);
      chk(rd, 32'hA5C3_3C5A);
      ev(0);
      ev(1);
      chk({core_reset, core_stall}, 2'h1);
      run_time(n);
      chk(32'(n > 2900), 32'h1);
      chk(core_wake, 1'b1);
      chk(status, {CAUSE_WDT_WAKE, 2'h0});
      pin_low(3);
      repeat (8) @(posedge clk_sys);
      chk(core_reset, 1'b0);
      pin_low(30);
      chk({core_reset, status}, {1'b1, CAUSE_PIN_RUN, 2'h0});
      run_time(n);
      chk(32'(n < 10), 32'h1);
      ev(0);
      pin_low(30);
      chk(status, {CAUSE_PIN_SLEEP, 2'h2});
      run_time(n);
      fuses <= '{HIGH_SPEED_CRYSTAL_MODE, 1'b1, 1'b1};
      supply_low(1000);
      repeat (4) @(posedge clk_sys);
      chk(core_reset, 1'b0);
      supply_low(2100);
      chk({core_reset, status}, {1'b1, CAUSE_BROWNOUT, 2'h3});
      repeat (8) @(posedge clk_sys);
      supply_low(5);
      run_time(n);
      chk(32'(n >= PW && n < PW + 20), 32'h1);
      apb(1'b0, POWER_CONTROL_REGISTER_OFFSET, 32'h0);
      chk(rd, 32'h2);
      print_verdict;
   end

   initial begin
      #2_000_000;
      bad_count++;
      print_verdict;
   end
endmodule // test_reset_timeout_sequencer
